// File: design/port_input_regs.vh
`ifndef PORT_INPUT_REGS_VH
`define PORT_INPUT_REGS_VH

// ==========================================================================
// Register byte addresses
`define ADDR_G0_BUFSEL   16'h5204
`define ADDR_G0_IRQEN    16'h5205
`define ADDR_G0_EDGE     16'h5206
`define ADDR_G0_FLAGS    16'h5207
`define ADDR_G0_DEBOUNCE 16'h5208
`define ADDR_G0_KEYRST   16'h5209
`define ADDR_G1_BUFSEL   16'h5214
`define ADDR_G1_IRQEN    16'h5215
`define ADDR_G1_EDGE     16'h5216
`define ADDR_G1_FLAGS    16'h5217
`define ADDR_G2_BUFSEL   16'h5224
`define ADDR_G3_BUFSEL   16'h5234

// ==========================================================================
// Reset values
`define RST_BUFSEL    8'hff
`define RST_G3_BUFSEL 4'hf
`define RST_ZERO8     8'h00

// ==========================================================================
// Field positions
`define DEB_LOW_LSB  0
`define DEB_HIGH_LSB 4
`define KEYRST_OFF   2'h0
`define KEYRST_2PIN  2'h1
`define KEYRST_3PIN  2'h2
`define KEYRST_4PIN  2'h3

// ==========================================================================
// Timing: shortest check time in peripheral-clock periods, code 1
`define DEB_BASE_CYCLES 16'h0100
`define DEB_CNT_W       16

`endif

// File: design/debounce_filter.v
`include "port_input_regs.vh"
`default_nettype none

// ==========================================================================
// Debounce for one pin: the level must hold through a whole check window.
// Pulses up to one window are dropped; longer than two always pass.
module debounce_filter (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       tick,
  input  wire       pinIn,
  output reg        pinOut_ff
);

  reg stable_ff;
  reg cand_ff;

  // Candidate level is taken at one tick and must hold until the next
  always @(posedge clock) begin
    if (!rst_n) begin
      stable_ff <= 1'b0;
      cand_ff   <= 1'b1;
      pinOut_ff <= 1'b1;
    end else if (tick) begin
      if (stable_ff && (pinIn == cand_ff))
        pinOut_ff <= pinIn;
      cand_ff   <= pinIn;
      stable_ff <= 1'b1;
    end else if (pinIn != cand_ff) begin
      stable_ff <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: design/port_input_ctrl.v
// Behaviour
// - Buffer-type bit set selects hysteresis input, clear selects CMOS; resets set.
// - Group three buffer-type has bits 3..0 only; upper bits read zero.
// - Groups zero and one have per-pin interrupt enables, reset to zero.
// - Edge on a disabled pin sets no flag and no request.
// - Edge select one means falling edge, zero rising edge, reset zero.
// - Enabled pin seeing its selected edge sets its flag.
// - Setting a flag raises that group's request line.
// - Writing one clears a flag, zero leaves it; read shows the flag.
// - Group zero debounce: bits 6..4 for pins 7..4, bits 2..0 pins 3..0.
// - Code zero filter off; codes 1..7 give 256 doubling to 16384 cycles.
// - Filter removes pulses up to one check time; accepts those longer than two.
// - Filter blocks wake-up interrupts in sleep; software turns it off first.
// - Key-reset field 3,2,1 select pins 0..3, 0..2, 0..1; zero off.
// - All selected pins low together raises the initial reset.
// - Key reset inactive until enabled and does not act in sleep.
//
// Chosen here: strobed register access.
`include "port_input_regs.vh"
`default_nettype none

module port_input_ctrl (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [15:0] addr,
  input  wire [7:0]  wrData,
  input  wire        wrStrobe,
  input  wire        rdStrobe,
  output reg  [7:0]  rdData_ff,
  input  wire [7:0]  grp0Pins,
  input  wire [7:0]  grp1Pins,
  input  wire        prescalerTick,
  input  wire        sleepMode,
  output reg  [7:0]  grp0Hysteresis_ff,
  output reg  [7:0]  grp1Hysteresis_ff,
  output reg  [7:0]  grp2Hysteresis_ff,
  output reg  [3:0]  grp3Hysteresis_ff,
  output reg         grp0IrqReq_ff,
  output reg         grp1IrqReq_ff,
  output reg         keyReset_ff
);

  // ========================================================================
  // Registers
  reg [7:0] grp0IrqEn_ff;
  reg [7:0] grp1IrqEn_ff;
  reg [7:0] grp0Edge_ff;
  reg [7:0] grp1Edge_ff;
  reg [7:0] grp0Flag_ff;
  reg [7:0] grp1Flag_ff;
  reg [2:0] debLow_ff;
  reg [2:0] debHigh_ff;
  reg [1:0] keyRstSel_ff;

  wire wrBufsel0   = wrStrobe && (addr == `ADDR_G0_BUFSEL);
  wire wrBufsel1   = wrStrobe && (addr == `ADDR_G1_BUFSEL);
  wire wrBufsel2   = wrStrobe && (addr == `ADDR_G2_BUFSEL);
  wire wrBufsel3   = wrStrobe && (addr == `ADDR_G3_BUFSEL);
  wire wrIrqEn0    = wrStrobe && (addr == `ADDR_G0_IRQEN);
  wire wrIrqEn1    = wrStrobe && (addr == `ADDR_G1_IRQEN);
  wire wrEdge0     = wrStrobe && (addr == `ADDR_G0_EDGE);
  wire wrEdge1     = wrStrobe && (addr == `ADDR_G1_EDGE);
  wire wrFlag0     = wrStrobe && (addr == `ADDR_G0_FLAGS);
  wire wrFlag1     = wrStrobe && (addr == `ADDR_G1_FLAGS);
  wire wrDebounce  = wrStrobe && (addr == `ADDR_G0_DEBOUNCE);
  wire wrKeyRst    = wrStrobe && (addr == `ADDR_G0_KEYRST);

  always @(posedge clock) begin
    if (!rst_n) begin
      grp0Hysteresis_ff <= `RST_BUFSEL;
      grp1Hysteresis_ff <= `RST_BUFSEL;
      grp2Hysteresis_ff <= `RST_BUFSEL;
      grp3Hysteresis_ff <= `RST_G3_BUFSEL;
      grp0IrqEn_ff      <= `RST_ZERO8;
      grp1IrqEn_ff      <= `RST_ZERO8;
      grp0Edge_ff       <= `RST_ZERO8;
      grp1Edge_ff       <= `RST_ZERO8;
      debLow_ff         <= 3'h0;
      debHigh_ff        <= 3'h0;
      keyRstSel_ff      <= `KEYRST_OFF;
    end else begin
      if (wrBufsel0)
        grp0Hysteresis_ff <= wrData;
      if (wrBufsel1)
        grp1Hysteresis_ff <= wrData;
      if (wrBufsel2)
        grp2Hysteresis_ff <= wrData;
      if (wrBufsel3)
        grp3Hysteresis_ff <= wrData[3:0];
      if (wrIrqEn0)
        grp0IrqEn_ff <= wrData;
      if (wrIrqEn1)
        grp1IrqEn_ff <= wrData;
      if (wrEdge0)
        grp0Edge_ff <= wrData;
      if (wrEdge1)
        grp1Edge_ff <= wrData;
      if (wrDebounce) begin
        debLow_ff  <= wrData[`DEB_LOW_LSB +: 3];
        debHigh_ff <= wrData[`DEB_HIGH_LSB +: 3];
      end
      if (wrKeyRst)
        keyRstSel_ff <= wrData[1:0];
    end
  end

  // ========================================================================
  // Pin synchronisers: three stages, change taken when stages two and three agree
  reg  [7:0] sync0A_ff, sync0B_ff, sync0C_ff, pin0_ff;
  reg  [7:0] sync1A_ff, sync1B_ff, sync1C_ff, pin1_ff;
  reg        sleepA_ff, sleepB_ff, sleepC_ff, sleep_ff;

  always @(posedge clock) begin
    if (!rst_n) begin
      sync0A_ff <= 8'hff;
      sync0B_ff <= 8'hff;
      sync0C_ff <= 8'hff;
      pin0_ff   <= 8'hff;
      sync1A_ff <= 8'hff;
      sync1B_ff <= 8'hff;
      sync1C_ff <= 8'hff;
      pin1_ff   <= 8'hff;
      sleepA_ff <= 1'b0;
      sleepB_ff <= 1'b0;
      sleepC_ff <= 1'b0;
      sleep_ff  <= 1'b0;
    end else begin
      sync0A_ff <= grp0Pins;
      sync0B_ff <= sync0A_ff;
      sync0C_ff <= sync0B_ff;
      pin0_ff   <= (sync0B_ff & sync0C_ff) | (pin0_ff & (sync0B_ff ^ sync0C_ff));
      sync1A_ff <= grp1Pins;
      sync1B_ff <= sync1A_ff;
      sync1C_ff <= sync1B_ff;
      pin1_ff   <= (sync1B_ff & sync1C_ff) | (pin1_ff & (sync1B_ff ^ sync1C_ff));
      sleepA_ff <= sleepMode;
      sleepB_ff <= sleepA_ff;
      sleepC_ff <= sleepB_ff;
      sleep_ff  <= (sleepB_ff == sleepC_ff) ? sleepB_ff : sleep_ff;
    end
  end

  // ========================================================================
  // Debounce timing: free counter of prescaler ticks, window per nibble
  // Windows are counted in prescaler ticks; with the prescaler at the
  // peripheral clock rate this gives exactly 256 << (code-1) periods.
  reg  [`DEB_CNT_W-1:0] debCnt_ff;
  wire [`DEB_CNT_W-1:0] lowLen  = `DEB_BASE_CYCLES << (debLow_ff - 3'h1);
  wire [`DEB_CNT_W-1:0] highLen = `DEB_BASE_CYCLES << (debHigh_ff - 3'h1);
  wire lowTick  = prescalerTick && ((debCnt_ff & (lowLen - 16'h0001)) == 16'h0000);
  wire highTick = prescalerTick && ((debCnt_ff & (highLen - 16'h0001)) == 16'h0000);

  always @(posedge clock) begin
    if (!rst_n)
      debCnt_ff <= 16'h0000;
    else if (prescalerTick)
      debCnt_ff <= debCnt_ff + 16'h0001;
  end

  wire [7:0] filtered0;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gen_deb
      debounce_filter u_deb (
        .clock     (clock),
        .rst_n     (rst_n),
        .tick      ((gi < 4) ? lowTick : highTick),
        .pinIn     (pin0_ff[gi]),
        .pinOut_ff (filtered0[gi])
      );
    end
  endgenerate

  wire [3:0] lowIn  = (debLow_ff == 3'h0) ? pin0_ff[3:0] : filtered0[3:0];
  wire [3:0] highIn = (debHigh_ff == 3'h0) ? pin0_ff[7:4] : filtered0[7:4];
  wire [7:0] edgeIn0 = {highIn, lowIn};

  // ========================================================================
  // Edge detection and flags
  reg [7:0] prev0_ff;
  reg [7:0] prev1_ff;

  wire [7:0] rise0 = edgeIn0 & ~prev0_ff;
  wire [7:0] fall0 = ~edgeIn0 & prev0_ff;
  wire [7:0] rise1 = pin1_ff & ~prev1_ff;
  wire [7:0] fall1 = ~pin1_ff & prev1_ff;
  // Filter holds levels across sleep unless ticks run, so events are lost there
  wire [7:0] hit0 = grp0IrqEn_ff & ((grp0Edge_ff & fall0) | (~grp0Edge_ff & rise0));
  wire [7:0] hit1 = grp1IrqEn_ff & ((grp1Edge_ff & fall1) | (~grp1Edge_ff & rise1));
  wire [7:0] clr0 = wrFlag0 ? wrData : 8'h00;
  wire [7:0] clr1 = wrFlag1 ? wrData : 8'h00;
  // Set wins over a simultaneous clear
  wire [7:0] nxt_grp0Flag = (grp0Flag_ff & ~clr0) | hit0;
  wire [7:0] nxt_grp1Flag = (grp1Flag_ff & ~clr1) | hit1;

  always @(posedge clock) begin
    if (!rst_n) begin
      prev0_ff      <= 8'hff;
      prev1_ff      <= 8'hff;
      grp0Flag_ff   <= `RST_ZERO8;
      grp1Flag_ff   <= `RST_ZERO8;
      grp0IrqReq_ff <= 1'b0;
      grp1IrqReq_ff <= 1'b0;
    end else begin
      prev0_ff      <= edgeIn0;
      prev1_ff      <= pin1_ff;
      grp0Flag_ff   <= nxt_grp0Flag;
      grp1Flag_ff   <= nxt_grp1Flag;
      grp0IrqReq_ff <= |nxt_grp0Flag;
      grp1IrqReq_ff <= |nxt_grp1Flag;
    end
  end

  // ========================================================================
  // Key-entry reset
  reg [3:0] keyMask;
  always @* begin
    case (keyRstSel_ff)
      `KEYRST_2PIN: keyMask = 4'h3;
      `KEYRST_3PIN: keyMask = 4'h7;
      `KEYRST_4PIN: keyMask = 4'hf;
      default:      keyMask = 4'h0;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n)
      keyReset_ff <= 1'b0;
    else
      keyReset_ff <= (keyMask != 4'h0) && !sleep_ff &&
                     ((pin0_ff[3:0] & keyMask) == 4'h0);
  end

  // ========================================================================
  // Read path, data in the cycle after the strobe
  reg [7:0] rdMux;
  always @* begin
    case (addr)
      `ADDR_G0_BUFSEL:   rdMux = grp0Hysteresis_ff;
      `ADDR_G1_BUFSEL:   rdMux = grp1Hysteresis_ff;
      `ADDR_G2_BUFSEL:   rdMux = grp2Hysteresis_ff;
      `ADDR_G3_BUFSEL:   rdMux = {4'h0, grp3Hysteresis_ff};
      `ADDR_G0_IRQEN:    rdMux = grp0IrqEn_ff;
      `ADDR_G1_IRQEN:    rdMux = grp1IrqEn_ff;
      `ADDR_G0_EDGE:     rdMux = grp0Edge_ff;
      `ADDR_G1_EDGE:     rdMux = grp1Edge_ff;
      `ADDR_G0_FLAGS:    rdMux = grp0Flag_ff;
      `ADDR_G1_FLAGS:    rdMux = grp1Flag_ff;
      `ADDR_G0_DEBOUNCE: rdMux = {1'b0, debHigh_ff, 1'b0, debLow_ff};
      `ADDR_G0_KEYRST:   rdMux = {6'h00, keyRstSel_ff};
      default:           rdMux = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n)
      rdData_ff <= 8'h00;
    else if (rdStrobe)
      rdData_ff <= rdMux;
    else
      rdData_ff <= 8'h00;
  end

endmodule

`default_nettype wire

// File: verification/port_input_ctrl_chk.sv
`default_nettype none
// ====================================================================
// Port relations of the pin input control block
module port_input_ctrl_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wrData,
  input wire logic        wrStrobe,
  input wire logic        rdStrobe,
  input wire logic [7:0]  rdData_ff,
  input wire logic [7:0]  grp0Pins,
  input wire logic        sleepMode,
  input wire logic [7:0]  grp0Hysteresis_ff,
  input wire logic [3:0]  grp3Hysteresis_ff,
  input wire logic        grp0IrqReq_ff,
  input wire logic        grp1IrqReq_ff,
  input wire logic        keyReset_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence wrAt(a);
    wrStrobe && addr == a;
  endsequence
  sequence clrAll(a);
    wrStrobe && addr == a && wrData == 8'hff;
  endsequence
  chk_read_idle_zero: assert property (!$past(rdStrobe) |-> rdData_ff == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_bufsel_g0_write: assert property (wrAt(16'h5204) |=> grp0Hysteresis_ff == $past(wrData))
    else $error("group zero buffer select did not take the write");
  chk_bufsel_g3_write: assert property (wrAt(16'h5234) |=> grp3Hysteresis_ff == $past(wrData[3:0]))
    else $error("group three buffer select did not take the write");
  chk_req0_fall_cause: assert property ($fell(grp0IrqReq_ff) |-> $past(wrStrobe && addr == 16'h5207))
    else $error("group zero request fell without a flag clear");
  chk_req1_clear_all: assert property (clrAll(16'h5217) |=> !grp1IrqReq_ff)
    else $error("group one request stayed after clearing all flags");
  chk_flag_read_idle: assert property (rdStrobe && addr == 16'h5207 && !grp0IrqReq_ff |=> rdData_ff == 8'h00)
    else $error("flag read shows a flag while request is low");
  chk_sleep_blocks_key: assert property (sleepMode [*8] |-> !keyReset_ff)
    else $error("key reset raised during sleep");
  chk_key_needs_low: assert property ((grp0Pins[1:0] != 2'b00) [*8] |-> !keyReset_ff)
    else $error("key reset raised while first pins high");
endmodule
bind port_input_ctrl port_input_ctrl_chk chk (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData_ff(rdData_ff),
  .grp0Pins(grp0Pins), .sleepMode(sleepMode), .grp0Hysteresis_ff(grp0Hysteresis_ff),
  .grp3Hysteresis_ff(grp3Hysteresis_ff), .grp0IrqReq_ff(grp0IrqReq_ff),
  .grp1IrqReq_ff(grp1IrqReq_ff), .keyReset_ff(keyReset_ff));
`default_nettype wire

// File: verification/key_pads.sv
`default_nettype none
// ====================================================================
// Keys on the pins, with optional contact chatter on group zero
module key_pads (
  input  wire logic       clock,
  input  wire logic [7:0] want0,
  input  wire logic [7:0] want1,
  input  wire logic [3:0] bounce,
  output var  logic [7:0] pins0,
  output var  logic [7:0] pins1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] old0;
  logic [7:0] now0;
  logic [3:0] cnt;
  // Pulled up: idle high until a key is pressed
  initial begin
    pins0 = 8'hff;
    pins1 = 8'hff;
    old0 = 8'hff;
    now0 = 8'hff;
    cnt = 4'h0;
  end
  // Chatter flips between old and new level for bounce cycles
  always @(posedge clock) begin
    if (want0 != now0) begin
      old0 <= now0;
      now0 <= want0;
      cnt <= bounce;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    pins0 <= cnt[0] ? old0 : now0;
    pins1 <= want1;
  end
endmodule
`default_nettype wire

// File: verification/test_port_input_ctrl.sv
`include "port_input_regs.vh"
`default_nettype none
module test_port_input_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_n, wrStrobe, rdStrobe, sleepMode, req0, req1, keyReset;
  logic [15:0] addr;
  logic [7:0]  wrData, rdData_ff, want0, want1, grp0Pins, grp1Pins, hys0, hys1, hys2;
  logic [3:0]  hys3, bounce;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [15:0] regA [12] = '{`ADDR_G0_BUFSEL, `ADDR_G0_IRQEN, `ADDR_G0_EDGE, `ADDR_G0_FLAGS,
    `ADDR_G0_DEBOUNCE, `ADDR_G0_KEYRST, `ADDR_G1_BUFSEL, `ADDR_G1_IRQEN, `ADDR_G1_EDGE,
    `ADDR_G1_FLAGS, `ADDR_G2_BUFSEL, `ADDR_G3_BUFSEL};
  logic [7:0]  rstV [12] = '{8'hff, 0, 0, 0, 0, 0, 8'hff, 0, 0, 0, 8'hff, 8'h0f};
  logic [7:0]  msk [12] = '{8'hff, 8'hff, 8'hff, 0, 8'h77, 8'h03, 8'hff, 8'hff, 8'hff, 0,
    8'hff, 8'h0f};
  port_input_ctrl DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData_ff(rdData_ff), .grp0Pins(grp0Pins),
    .grp1Pins(grp1Pins), .prescalerTick(1'b1), .sleepMode(sleepMode),
    .grp0Hysteresis_ff(hys0), .grp1Hysteresis_ff(hys1), .grp2Hysteresis_ff(hys2),
    .grp3Hysteresis_ff(hys3), .grp0IrqReq_ff(req0), .grp1IrqReq_ff(req1),
    .keyReset_ff(keyReset));
  key_pads pads (.clock(clock), .want0(want0), .want1(want1), .bounce(bounce),
    .pins0(grp0Pins), .pins1(grp1Pins));
  // ==================================================================
  // Bus and compare tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 check(rdData_ff, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic drive(input logic g, input logic [7:0] v);
    @(posedge clock);
    if (g) want1 <= v;
    else want0 <= v;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Pin three as the enabled source, pin four toggled while disabled
  task automatic irqCase(input logic g, input logic e);
    logic [15:0] b;
    b = g ? 16'h5210 : 16'h5200;
    wr(b + 16'h0007, 8'hff);
    wr(b + 16'h0006, {8{e}});
    wr(b + 16'h0005, 8'h08);
    drive(g, 8'hef);
    cyc(10);
    drive(g, 8'hff);
    cyc(10);
    rdchk(b + 16'h0007, 8'h00);
    drive(g, 8'hf7);
    cyc(10);
    rdchk(b + 16'h0007, {4'h0, e, 3'h0});
    drive(g, 8'hff);
    for (int i = 0; i < 20 && (g ? req1 : req0) !== 1'b1; i++) @(posedge clock);
    check({7'h0, (g ? req1 : req0)}, 8'h01);
    check({7'h0, (g ? req0 : req1)}, 8'h00);
    wr(b + 16'h0007, 8'h00);
    rdchk(b + 16'h0007, 8'h08);
    wr(b + 16'h0007, 8'hff);
    cyc(1);
    check({7'h0, (g ? req1 : req0)}, 8'h00);
    wr(b + 16'h0005, 8'h00);
  endtask
  // ==================================================================
  // Clock, watchdog and test sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    close_out();
  end
  initial begin
    {rst_n, wrStrobe, rdStrobe, sleepMode, addr, wrData, bounce} = '0;
    want0 = 8'hff;
    want1 = 8'hff;
    cyc(20);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rdchk(regA[i], rstV[i]);
    wr(16'h5200, 8'hff);
    rdchk(16'h5200, 8'h00);
    for (int i = 0; i < 12; i++) wr(regA[i], 8'h5a);
    cyc(1);
    check(hys0 & hys1 & hys2, 8'h5a);
    check({4'h0, hys3}, 8'h0a);
    for (int i = 0; i < 12; i++) begin
      rdchk(regA[i], 8'h5a & msk[i]);
      wr(regA[i], 8'h00);
    end
    done("registers");
    for (int k = 0; k < 4; k++) irqCase(k[1], k[0]);
    done("pin interrupts");
    wr(`ADDR_G0_DEBOUNCE, 8'h01);
    wr(`ADDR_G0_EDGE, 8'h01);
    wr(`ADDR_G0_FLAGS, 8'hff);
    wr(`ADDR_G0_IRQEN, 8'h01);
    bounce = 4'h7;
    for (int k = 0; k < 2; k++) begin
      drive(1'b0, 8'hfe);
      cyc(k ? 600 : 200);
      drive(1'b0, 8'hff);
      cyc(600);
      rdchk(`ADDR_G0_FLAGS, {7'h0, k[0]});
    end
    wr(`ADDR_G0_IRQEN, 8'h00);
    wr(`ADDR_G0_DEBOUNCE, 8'h00);
    bounce = 4'h0;
    done("debounce");
    drive(1'b0, 8'hf0);
    cyc(10);
    check({7'h0, keyReset}, 8'h00);
    drive(1'b0, 8'hff);
    cyc(10);
    for (int k = 1; k < 4; k++) begin
      wr(`ADDR_G0_KEYRST, k[7:0]);
      drive(1'b0, 8'(8'hff << k));
      cyc(10);
      check({7'h0, keyReset}, 8'h00);
      drive(1'b0, 8'(8'hff << (k + 1)));
      cyc(10);
      check({7'h0, keyReset}, 8'h01);
      sleepMode <= 1'b1;
      cyc(10);
      check({7'h0, keyReset}, 8'h00);
      sleepMode <= 1'b0;
      drive(1'b0, 8'hff);
      cyc(10);
    end
    done("key reset");
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rdchk(`ADDR_G0_KEYRST, 8'h00);
    done("second reset");
    close_out();
  end
endmodule
`default_nettype wire
